// ### include/io_exchange_pkg.sv
// shared constants and types of the programmed i/o exchange handshake
package io_exchange_pkg;
  // ==========================================================
  // clock and timing
  localparam int CLK_PERIOD_PS = 4000; // sys_clk period, 250 MHz
  localparam int ADDR_HOLD_NS = 50; // address kept before data cycle
  // least time: round up to whole cycles
  localparam int ADDR_HOLD_CYC =
    (ADDR_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TIMEOUT_US = 8; // bus cycle limit
  // longest time: round down to whole cycles
  localparam int TIMEOUT_CYC = (TIMEOUT_US * 1000000) / CLK_PERIOD_PS;
  localparam int TIMER_W = 12; // wide enough for TIMEOUT_CYC
  localparam int HOLD_W = 5; // wide enough for ADDR_HOLD_CYC

  // ==========================================================
  // widths and address fields
  localparam int DATA_W = 16; // a register width
  localparam int BUS_W = 24; // multiplexed bus data lines
  localparam int DEV_LSB = 3; // device number above register bits
  localparam int DEV_W = 8; // device number width
  localparam logic [7:0] DEV_TERMINAL1 = 8'hC0; // 300 octal
  localparam logic [7:0] DEV_RTC = 8'h08; // 10 octal
  localparam logic [3:0] TIMEOUT_IRQ_LEVEL = 4'hE; // level 14

  // ==========================================================
  // synchroniser line indices
  localparam int LINE_DRY = 0; // data_ready_reply
  localparam int LINE_INREQ = 1; // input_request
  localparam int SYNC_LINES = 2;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    CYC_MEMREF, CYC_IOX, CYC_IDENT
  } cycle_kind_t;

  // microaddress map entry: illegal use selects the error row
  function automatic logic [1:0] map_entry(input logic illegal,
                                           input logic ext);
    map_entry = {illegal, ext};
  endfunction

  // devices that live on the cpu module itself
  function automatic logic is_local_dev(input logic [15:0] addr);
    logic [DEV_W-1:0] dev;
    dev = addr[DEV_LSB +: DEV_W];
    is_local_dev = (dev == DEV_TERMINAL1) || (dev == DEV_RTC);
  endfunction
endpackage

// ### include/bus_sync_if.sv
// carrier between the handshake core and its line synchroniser
`timescale 1ns/1ps
interface bus_sync_if;
  import io_exchange_pkg::*;
  logic [SYNC_LINES-1:0] raw_n; // asynchronous bus lines
  logic [SYNC_LINES-1:0] lvl_n; // synchronised levels
  logic [SYNC_LINES-1:0] fall; // one-cycle leading edge pulses
  modport syncer (input raw_n, output lvl_n, output fall);
  modport user (output raw_n, input lvl_n, input fall);
endinterface

// ### src/bus_line_sync.sv
// two-flop synchronisers with leading edge detect for bus replies
`timescale 1ns/1ps
module bus_line_sync
  import io_exchange_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // lines
  bus_sync_if.syncer sy
);
  // ==========================================================
  // state
  logic [SYNC_LINES-1:0] meta; // first stage, read by stage two only
  logic [SYNC_LINES-1:0] stable; // second stage
  logic [SYNC_LINES-1:0] prev; // for edge detect
  logic [SYNC_LINES-1:0] next_meta;
  logic [SYNC_LINES-1:0] next_stable;
  logic [SYNC_LINES-1:0] next_prev;

  // shift chain
  always_comb begin
    next_meta = sy.raw_n;
    next_stable = meta;
    next_prev = stable;
  end

  // idle lines are high; reset matches that to avoid a false edge
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      meta <= '1;
      stable <= '1;
      prev <= '1;
    end else begin
      meta <= next_meta;
      stable <= next_stable;
      prev <= next_prev;
    end
  end

  assign sy.lvl_n = stable;
  assign sy.fall = prev & ~stable;
endmodule // bus_line_sync

// ### src/io_exchange_bus_handshake.sv
// cpu-side exchange entry check and backplane bus handshake
`timescale 1ns/1ps
module io_exchange_bus_handshake
  import io_exchange_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // microprogram side
  input wire logic mp_start,
  input wire logic mp_ext,
  input wire cycle_kind_t mp_kind,
  input wire logic [15:0] mp_dev_addr,
  input wire logic [DATA_W-1:0] mp_a_value,
  output logic mp_wait,
  output logic [1:0] map_addr,
  output logic error_entry,
  output logic a_load,
  output logic [DATA_W-1:0] data_bus_latch,
  // memory management
  input wire logic mm_active,
  input wire logic privilege_enable,
  // on-module devices
  output logic local_req,
  output logic [15:0] local_addr,
  output logic [DATA_W-1:0] local_wdata,
  input wire logic local_ack,
  input wire logic [DATA_W-1:0] local_rdata,
  // bus control unit
  output logic bus_req,
  output cycle_kind_t bus_kind,
  input wire logic bus_alloc_ack,
  output logic timeout_irq,
  output logic [3:0] timeout_level,
  // backplane
  input wire logic [BUS_W-1:0] bus_data_in,
  output logic [BUS_W-1:0] bus_data_out,
  output logic bus_data_oe,
  output logic address_present_strobe_n,
  output logic io_exchange_enable_n,
  output logic input_grant_n,
  input wire logic data_ready_reply_n,
  input wire logic input_request_n
);
  // ==========================================================
  // states and registers
  typedef enum logic [3:0] {
    ST_IDLE, ST_LOCAL, ST_ALLOC, ST_ADDR, ST_DRIVE,
    ST_DATA, ST_TURN, ST_INPUT, ST_RELEASE
  } state_t;
  localparam logic [TIMER_W-1:0] TIMER_LAST =
    TIMER_W'(TIMEOUT_CYC - 1);
  localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(ADDR_HOLD_CYC - 1);
  localparam int HOLD_SPAN = ADDR_HOLD_CYC + 1; // strobe to enable

  state_t st, next_st; // sequencer
  logic [DATA_W-1:0] write_data_addr_buffer, next_wda; // write data / address buffer
  logic [HOLD_W-1:0] hold, next_hold; // address hold count
  logic [TIMER_W-1:0] timer, next_timer; // bus cycle timer
  logic next_mp_wait, next_error_entry, next_a_load;
  logic [1:0] next_map_addr;
  logic [DATA_W-1:0] next_latch;
  logic next_local_req;
  logic [15:0] next_local_addr;
  logic [DATA_W-1:0] next_local_wdata;
  logic next_bus_req, next_timeout_irq;
  cycle_kind_t next_bus_kind;
  logic [BUS_W-1:0] next_bus_data_out;
  logic next_oe, next_apst_n, next_ioxe_n, next_grant_n;
  logic legal; // privilege decision
  logic timer_run; // bus is allocated to us
  logic abort; // cycle over its time limit
  logic dry_fall, inreq_fall, dry_idle;

  bus_sync_if sif ();

  // ==========================================================
  // reply synchronisers
  assign sif.raw_n[LINE_DRY] = data_ready_reply_n;
  assign sif.raw_n[LINE_INREQ] = input_request_n;
  bus_line_sync u_sync (
    .sys_clk (sys_clk),
    .nrst (nrst),
    .sy (sif.syncer)
  );
  assign dry_fall = sif.fall[LINE_DRY];
  assign inreq_fall = sif.fall[LINE_INREQ];
  assign dry_idle = sif.lvl_n[LINE_DRY];

  // ==========================================================
  // decisions
  // privilege_enable already carries the ring test from the mmu
  assign legal = !mm_active || privilege_enable;
  assign timer_run = (st != ST_IDLE) && (st != ST_LOCAL)
    && (st != ST_ALLOC);
  assign abort = timer_run && (timer == TIMER_LAST);

  // next values of the whole sequencer
  always_comb begin
    next_st = st;
    next_wda = write_data_addr_buffer;
    next_hold = hold;
    next_timer = timer_run ? timer + 1'b1 : '0;
    next_mp_wait = mp_wait;
    next_map_addr = map_addr;
    next_error_entry = 1'b0; // pulses
    next_a_load = 1'b0;
    next_latch = data_bus_latch;
    next_local_req = 1'b0;
    next_local_addr = local_addr;
    next_local_wdata = local_wdata;
    next_bus_req = bus_req;
    next_bus_kind = bus_kind;
    next_timeout_irq = 1'b0;
    next_bus_data_out = bus_data_out;
    next_oe = bus_data_oe;
    next_apst_n = address_present_strobe_n;
    next_ioxe_n = io_exchange_enable_n;
    next_grant_n = input_grant_n;
    if (abort) begin
      // stuck cycle: free the bus, report, unstall
      next_st = ST_IDLE;
      next_timeout_irq = 1'b1;
      next_mp_wait = 1'b0;
      next_bus_req = 1'b0;
      next_oe = 1'b0;
      next_apst_n = 1'b1;
      next_ioxe_n = 1'b1;
      next_grant_n = 1'b1;
    end else begin
      case (st)
        ST_IDLE: begin
          if (mp_start) begin
            next_map_addr = map_entry(!legal, mp_ext);
            if (!legal) begin
              // error routine entered, exchange never starts
              next_error_entry = 1'b1;
            end else if (is_local_dev(mp_dev_addr)) begin
              next_local_req = 1'b1;
              next_local_addr = mp_dev_addr;
              next_local_wdata = mp_a_value;
              next_mp_wait = 1'b1;
              next_st = ST_LOCAL;
            end else begin
              next_bus_req = 1'b1;
              next_bus_kind = mp_kind;
              next_wda = mp_dev_addr;
              next_mp_wait = 1'b1;
              next_st = ST_ALLOC;
            end
          end
        end
        ST_LOCAL: begin
          if (local_ack) begin
            next_latch = local_rdata;
            next_a_load = 1'b1;
            next_mp_wait = 1'b0;
            next_st = ST_IDLE;
          end
        end
        ST_ALLOC: begin
          // timer starts from zero at allocation
          if (bus_alloc_ack) begin
            next_bus_data_out = BUS_W'(write_data_addr_buffer);
            next_oe = 1'b1;
            next_apst_n = 1'b0;
            next_hold = '0;
            next_st = ST_ADDR;
          end
        end
        ST_ADDR: begin
          next_hold = hold + 1'b1;
          if (hold == HOLD_LAST) begin
            // address cycle over: a register goes out either way
            next_apst_n = 1'b1;
            next_wda = mp_a_value;
            next_bus_data_out = BUS_W'(mp_a_value);
            next_st = ST_DRIVE;
          end
        end
        ST_DRIVE: begin
          next_ioxe_n = 1'b0;
          next_st = ST_DATA;
        end
        ST_DATA: begin
          if (dry_fall) begin
            // output case: bus still holds a, so a is unchanged
            next_latch = bus_data_in[DATA_W-1:0];
            next_a_load = 1'b1;
            next_mp_wait = 1'b0;
            next_ioxe_n = 1'b1;
            next_st = ST_RELEASE;
          end else if (inreq_fall) begin
            next_oe = 1'b0;
            next_st = ST_TURN;
          end
        end
        ST_TURN: begin
          // one full cycle with the bus released before grant
          next_grant_n = 1'b0;
          next_st = ST_INPUT;
        end
        ST_INPUT: begin
          if (dry_fall) begin
            next_latch = bus_data_in[DATA_W-1:0];
            next_a_load = 1'b1;
            next_mp_wait = 1'b0;
            next_ioxe_n = 1'b1;
            next_grant_n = 1'b1;
            next_st = ST_RELEASE;
          end
        end
        ST_RELEASE: begin
          // bus stays ours until the interface drops its reply
          if (dry_idle) begin
            next_bus_req = 1'b0;
            next_oe = 1'b0;
            next_st = ST_IDLE;
          end
        end
        default: begin
          next_st = ST_IDLE;
        end
      endcase
    end
  end

  // registers only
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st <= ST_IDLE;
      write_data_addr_buffer <= '0;
      hold <= '0;
      timer <= '0;
      mp_wait <= 1'b0;
      map_addr <= 2'h0;
      error_entry <= 1'b0;
      a_load <= 1'b0;
      data_bus_latch <= '0;
      local_req <= 1'b0;
      local_addr <= 16'h0000;
      local_wdata <= '0;
      bus_req <= 1'b0;
      bus_kind <= CYC_MEMREF;
      timeout_irq <= 1'b0;
      timeout_level <= 4'h0;
      bus_data_out <= '0;
      bus_data_oe <= 1'b0;
      address_present_strobe_n <= 1'b1;
      io_exchange_enable_n <= 1'b1;
      input_grant_n <= 1'b1;
    end else begin
      st <= next_st;
      write_data_addr_buffer <= next_wda;
      hold <= next_hold;
      timer <= next_timer;
      mp_wait <= next_mp_wait;
      map_addr <= next_map_addr;
      error_entry <= next_error_entry;
      a_load <= next_a_load;
      data_bus_latch <= next_latch;
      local_req <= next_local_req;
      local_addr <= next_local_addr;
      local_wdata <= next_local_wdata;
      bus_req <= next_bus_req;
      bus_kind <= next_bus_kind;
      timeout_irq <= next_timeout_irq;
      timeout_level <= TIMEOUT_IRQ_LEVEL;
      bus_data_out <= next_bus_data_out;
      bus_data_oe <= next_oe;
      address_present_strobe_n <= next_apst_n;
      io_exchange_enable_n <= next_ioxe_n;
      input_grant_n <= next_grant_n;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  a_priv_gate: assert property (st == ST_IDLE && mp_start && mm_active
    && !privilege_enable |=> st == ST_IDLE && map_addr[1])
    else $error("privileged exchange started without privilege");
  a_illegal_entry: assert property (st == ST_IDLE && mp_start && !legal
    |=> error_entry && !bus_req && !mp_wait)
    else $error("illegal use did not take the error entry");
  a_local_serve: assert property (st == ST_IDLE && mp_start && legal
    && is_local_dev(mp_dev_addr) |=> local_req && !bus_req)
    else $error("local device went to the backplane");
  a_wait_alloc: assert property (bus_req && st == ST_ALLOC
    |-> mp_wait)
    else $error("microprogram not stalled while waiting for bus");
  a_strobe_ack: assert property (st == ST_ALLOC && bus_alloc_ack
    |=> !address_present_strobe_n && bus_data_oe
    && bus_data_out == BUS_W'($past(write_data_addr_buffer)))
    else $error("address not driven on allocation acknowledge");
  a_addr_hold: assert property ($fell(address_present_strobe_n)
    |-> ##HOLD_SPAN $fell(io_exchange_enable_n))
    else $error("address hold time before data cycle wrong");
  a_data_first: assert property ($fell(io_exchange_enable_n)
    |-> bus_data_oe && $past(bus_data_oe))
    else $error("exchange enabled before data was on the bus");
  a_latch_reply: assert property (dry_fall && !abort
    && (st == ST_DATA || st == ST_INPUT)
    |=> data_bus_latch == $past(bus_data_in[DATA_W-1:0]) && a_load
    && io_exchange_enable_n && !mp_wait)
    else $error("reply edge did not capture and restart");
  a_turn_order: assert property ($fell(input_grant_n)
    |-> !bus_data_oe && !$past(bus_data_oe))
    else $error("input grant given while still driving the bus");
  a_timeout: assert property (abort |=> timeout_irq
    && st == ST_IDLE && !bus_req && timeout_level == 4'hE)
    else $error("timed out cycle not aborted and reported");
endmodule // io_exchange_bus_handshake

// ### testbench/io_bus_partner.sv
// behavioural model of an i/o interface's bus control logic
`timescale 1ns/1ps
module io_bus_partner
  import io_exchange_pkg::*;
(
  // clock used only to pace replies
  input wire logic sys_clk,
  // backplane from the cpu side
  input wire logic [BUS_W-1:0] bus_data_out,
  input wire logic address_present_strobe_n,
  input wire logic io_exchange_enable_n,
  input wire logic input_grant_n,
  // replies to the cpu side
  output logic data_ready_reply_n,
  output logic input_request_n,
  output logic drive_oe,
  output logic [BUS_W-1:0] drive_data,
  // bench controls and observation
  input wire logic silent,
  input wire logic [3:0] delay,
  input wire logic [DATA_W-1:0] in_data,
  output logic [DATA_W-1:0] last_out
);
  // ==========================================================
  // one exchange per pass; odd register numbers are inputs
  logic [15:0] addr; // address buffered on the strobe
  initial begin
    data_ready_reply_n = 1'b1;
    input_request_n = 1'b1;
    drive_oe = 1'b0;
    drive_data = '0;
    last_out = '0;
    addr = '0;
    forever begin
      @(negedge address_present_strobe_n);
      #1 addr = bus_data_out[15:0];
      @(negedge io_exchange_enable_n);
      // a silent interface lets the cycle run into the abort
      if (!silent) begin
        repeat (delay) @(posedge sys_clk);
        #1;
        if (addr[0]) begin
          input_request_n = 1'b0;
          @(negedge input_grant_n);
          #1 drive_data = {8'h00, in_data};
          drive_oe = 1'b1;
          repeat (delay) @(posedge sys_clk);
          #1;
        end else begin
          last_out = bus_data_out[15:0];
        end
        data_ready_reply_n = 1'b0;
        @(posedge io_exchange_enable_n);
        // released lines no longer show data: the bench inverts them
        #1 data_ready_reply_n = 1'b1;
        input_request_n = 1'b1;
        drive_oe = 1'b0;
      end
    end
  end
endmodule // io_bus_partner

// ### testbench/test_io_exchange_bus_handshake.sv
// self-checking bench of the exchange handshake block
`timescale 1ns/1ps
module test_io_exchange_bus_handshake
  import io_exchange_pkg::*;
;
  // ==========================================================
  // signals
  logic sys_clk, nrst, mp_start, mp_ext, mp_wait, error_entry, a_load;
  logic mm_active, privilege_enable, local_req, local_ack, bus_req;
  logic bus_alloc_ack, timeout_irq, bus_data_oe, input_grant_n;
  logic address_present_strobe_n, io_exchange_enable_n, p_oe, silent;
  logic data_ready_reply_n, input_request_n, cur_ext, cur_quiet;
  cycle_kind_t mp_kind, bus_kind, cur_kind;
  logic [1:0] map_addr;
  logic [3:0] timeout_level, p_delay;
  logic [15:0] mp_dev_addr, local_addr, cur_addr, addr;
  logic [DATA_W-1:0] mp_a_value, data_bus_latch, local_wdata, local_rdata;
  logic [DATA_W-1:0] in_data, last_out, cur_a, a;
  logic [BUS_W-1:0] bus_data_in, bus_data_out, p_data, last_bus;
  logic [17:0] exp_q[$]; // notes: {event code, data}
  int errors = 0, n_tests = 0, cycles = 0, hold = 0;
  integer seed = 32'he1fe;

  // ==========================================================
  // clock, design and partner
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  io_exchange_bus_handshake io_exchange_bus_handshake_inst (.*);
  io_bus_partner io_bus_partner_inst (
    .sys_clk(sys_clk), .bus_data_out(bus_data_out),
    .address_present_strobe_n(address_present_strobe_n),
    .io_exchange_enable_n(io_exchange_enable_n),
    .input_grant_n(input_grant_n), .data_ready_reply_n(data_ready_reply_n),
    .input_request_n(input_request_n), .drive_oe(p_oe), .drive_data(p_data),
    .silent(silent), .delay(p_delay), .in_data(in_data),
    .last_out(last_out));

  // wire level; an undriven bus toggles so stale data never matches
  always_comb begin
    if (bus_data_oe) bus_data_in = bus_data_out;
    else if (p_oe) bus_data_in = p_data;
    else bus_data_in = ~last_bus;
  end
  // allocation and on-module device stand-ins answer one cycle late
  always @(posedge sys_clk) begin
    last_bus <= bus_data_in;
    bus_alloc_ack <= #1 bus_req;
    local_ack <= #1 local_req;
  end

  // ==========================================================
  // reporting
  task automatic check(input string what, input logic [23:0] exp,
                       input logic [23:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict;
    if (errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // hang guard, well above the abort scenario plus traffic
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 8000) begin
      errors++;
      give_verdict();
    end
  end

  // ==========================================================
  // watcher: takes the oldest note whenever a result appears
  always @(posedge sys_clk) begin
    logic [1:0] code;
    logic [17:0] e;
    if (nrst) begin
      code = error_entry ? 2'h1 : (timeout_irq ? 2'h2 : 2'h0);
      if (a_load === 1'b1 || error_entry === 1'b1 ||
          timeout_irq === 1'b1) begin
        e = (exp_q.size() > 0) ? exp_q.pop_front() : 18'h3FFFF;
        check("event code", e[17:16], code);
        if (code == 2'h0) check("latch", e[15:0], data_bus_latch);
        if (code == 2'h1) check("map_addr", {1'b1, cur_ext}, map_addr);
        if (code == 2'h2) check("level", 4'hE, timeout_level);
      end
      if ($fell(address_present_strobe_n)) begin
        hold = 0;
        check("address", {8'h00, cur_addr}, bus_data_out);
        check("bus_kind", cur_kind, bus_kind);
      end
      if (!address_present_strobe_n) hold++;
      if ($rose(address_present_strobe_n))
        check("hold", 24'h1, hold >= ADDR_HOLD_CYC);
      if ($fell(io_exchange_enable_n)) begin
        check("write data", {8'h00, cur_a}, bus_data_out);
        check("mp_wait", 24'h1, mp_wait);
      end
      if (input_grant_n === 1'b0) check("oe", 24'h0, bus_data_oe);
      if (local_req === 1'b1) begin
        check("local_addr", cur_addr, local_addr);
        check("local_wdata", cur_a, local_wdata);
      end
      if (cur_quiet && bus_req !== 1'b0) check("bus_req", 24'h0, bus_req);
    end
  end

  // ==========================================================
  // one exchange: note the outcome, pulse start, wait for the note
  task automatic xchg(input logic [15:0] ad, input logic [15:0] av,
                      input logic [1:0] code, input logic [15:0] ev);
    int n;
    logic [1:0] k;
    k = 2'($unsigned($random(seed)) % 3);
    cur_kind = cycle_kind_t'(k);
    cur_addr = ad;
    cur_a = av;
    cur_ext = 1'($random(seed));
    cur_quiet = (mm_active && !privilege_enable) ||
                ad[10:3] == DEV_TERMINAL1 || ad[10:3] == DEV_RTC;
    mp_dev_addr = ad;
    mp_a_value = av;
    mp_ext = cur_ext;
    mp_kind = cur_kind;
    exp_q.push_back({code, ev});
    mp_start = 1'b1;
    @(posedge sys_clk);
    #1 mp_start = 1'b0;
    n = 0;
    while (exp_q.size() > 0 && n < 3000) begin
      @(posedge sys_clk);
      #1 n++;
    end
    // a note never answered is a hang: count it, never let it pass
    if (exp_q.size() > 0) begin
      check("pending notes", 24'h0, 24'(exp_q.size()));
      exp_q.delete();
    end
    // the sequencer stays in release until the reply rises again
    repeat (8) @(posedge sys_clk);
    #1;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    nrst = 1'b0;
    mp_start = 1'b0;
    mp_ext = 1'b0;
    mp_kind = CYC_IOX;
    mp_dev_addr = 16'h0000;
    mp_a_value = 16'h0000;
    mm_active = 1'b0;
    privilege_enable = 1'b0;
    local_rdata = 16'h0000;
    silent = 1'b0;
    p_delay = 4'h0;
    in_data = 16'h0000;
    cur_quiet = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 nrst = 1'b1;
    check("idle strobes", 24'h7, {address_present_strobe_n,
          io_exchange_enable_n, input_grant_n});
    // every privilege combination; only managed and unprivileged fails
    for (int i = 0; i < 4; i++) begin
      {mm_active, privilege_enable} = i[1:0];
      a = 16'($random(seed));
      xchg(16'h0100, a, (i == 2) ? 2'h1 : 2'h0, a);
    end
    // both on-module devices never touch the backplane
    for (int j = 0; j < 2; j++) begin
      local_rdata = 16'($random(seed));
      addr = {5'h00, (j == 0) ? DEV_TERMINAL1 : DEV_RTC, 3'h5};
      xchg(addr, 16'($random(seed)), 2'h0, local_rdata);
    end
    // backplane traffic, both directions, prompt and slow partner
    for (int j = 0; j < 16; j++) begin
      addr = 16'($random(seed));
      addr[15:11] = 5'h00;
      if (addr[10:3] == DEV_TERMINAL1 || addr[10:3] == DEV_RTC)
        addr[9] = ~addr[9];
      if (j < 2) addr[0] = j[0];
      a = 16'($random(seed));
      in_data = 16'($random(seed));
      p_delay = 4'($random(seed));
      xchg(addr, a, 2'h0, addr[0] ? in_data : a);
      if (!addr[0]) check("written", a, last_out);
    end
    // a partner that never replies: the cycle is aborted
    silent = 1'b1;
    xchg(16'h0200, 16'h1234, 2'h2, 16'h0000);
    check("enable after abort", 24'h1, io_exchange_enable_n);
    check("bus_req after abort", 24'h0, bus_req);
    silent = 1'b0;
    xchg(16'h0208, 16'hA5C3, 2'h0, 16'hA5C3);
    give_verdict();
  end
endmodule // test_io_exchange_bus_handshake
